// *** logic/ebr_consts.svh ***
`ifndef EBR_CONSTS_SVH
`define EBR_CONSTS_SVH
// Array geometry
`define EBR_DEPTH       512
`define EBR_ADDR_W      9
`define EBR_DATA_W      36
`define EBR_LANES       4
`define EBR_LANE_W      9
`define EBR_DUAL_LANES  4'h3
// Register map, byte addresses
`define EBR_CTRL_OFS    4'h0
`define EBR_STAT_OFS    4'h4
// Control fields
`define EBR_CTRL_PIPE   0
`define EBR_CTRL_WMA_LO 1
`define EBR_CTRL_WMB_LO 3
`define EBR_CTRL_PM_LO  5
`define EBR_CTRL_RST    7'h00
// Status fields
`define EBR_STAT_BUSY   0
`endif

// *** logic/ebr_pkg.sv ***
package ebr_pkg;
   typedef enum logic [1:0] {
      EBR_PM_DUAL   = 2'h0,
      EBR_PM_SEMI   = 2'h1,
      EBR_PM_SINGLE = 2'h2,
      EBR_PM_RSVD   = 2'h3
   } ebr_pmode_t;
   typedef enum logic [1:0] {
      EBR_WM_NORMAL = 2'h0,
      EBR_WM_THRU   = 2'h1,
      EBR_WM_RBW    = 2'h2,
      EBR_WM_RSVD   = 2'h3
   } ebr_wmode_t;
endpackage : ebr_pkg

// *** logic/ebr_top.sv ***
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ebr_consts.svh"
module ebr_top
   import ebr_pkg::*;
(
   input  wire logic                   clk_in,              // System clock
   input  wire logic                   arst_n_in,           // Async reset, low
   input  wire logic [3:0]             avs_address_in,      // Register byte address
   input  wire logic                   avs_read_in,         // Register read
   input  wire logic                   avs_write_in,        // Register write
   input  wire logic [31:0]            avs_writedata_in,    // Register write data
   input  wire logic [3:0]             avs_byteenable_in,   // Register byte lanes
   output logic [31:0]                 avs_readdata_out,    // Register read data
   output logic                        avs_waitrequest_out, // Slave stall
   input  wire logic                   port_a_clock_enable_in,            // Port A access
   input  wire logic                   port_a_output_reg_clock_enable_in, // Port A out reg
   input  wire logic                   port_a_reset_in,     // Port A register reset
   input  wire logic                   port_a_write_enable_in, // Port A write
   input  wire logic [`EBR_ADDR_W-1:0] port_a_addr_in,      // Port A address
   input  wire logic [`EBR_DATA_W-1:0] port_a_wdata_in,     // Port A write data
   input  wire logic [`EBR_LANES-1:0]  port_a_byte_en_in,   // Port A lane enables
   output logic [`EBR_DATA_W-1:0]      port_a_read_data_out, // Port A read data
   input  wire logic                   port_b_clock_enable_in,            // Port B access
   input  wire logic                   port_b_output_reg_clock_enable_in, // Port B out reg
   input  wire logic                   port_b_reset_in,     // Port B register reset
   input  wire logic                   port_b_write_enable_in, // Port B write
   input  wire logic [`EBR_ADDR_W-1:0] port_b_addr_in,      // Port B address
   input  wire logic [`EBR_DATA_W-1:0] port_b_wdata_in,     // Port B write data
   input  wire logic [`EBR_LANES-1:0]  port_b_byte_en_in,   // Port B lane enables
   output logic [`EBR_DATA_W-1:0]      port_b_read_data_out, // Port B read data
   output logic                        init_busy_out        // Initialisation running
);

   // Lane merge of new data over old word
   function automatic logic [`EBR_DATA_W-1:0] merge_word(
      input logic [`EBR_DATA_W-1:0] old_w,
      input logic [`EBR_DATA_W-1:0] new_w,
      input logic [`EBR_LANES-1:0]  be);
      logic [`EBR_DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < `EBR_LANES; i++) begin
         if (be[i]) begin
            res[i*`EBR_LANE_W +: `EBR_LANE_W] = new_w[i*`EBR_LANE_W +: `EBR_LANE_W];
         end
      end
      return res;
   endfunction : merge_word

   // Array output register value for one port
   function automatic logic [`EBR_DATA_W-1:0] arr_next(
      input logic [`EBR_DATA_W-1:0] cur,
      input logic                   acc,
      input logic                   wr,
      input ebr_wmode_t             wm,
      input logic [`EBR_DATA_W-1:0] q,
      input logic [`EBR_DATA_W-1:0] word);
      logic [`EBR_DATA_W-1:0] res;
      res = cur;
      if (acc && !wr) begin
         res = q;
      end else if (acc) begin
         unique case (wm)
            EBR_WM_NORMAL: res = cur;
            EBR_WM_THRU:   res = word;
            EBR_WM_RBW:    res = q;
            default:       res = cur;
         endcase
      end
      return res;
   endfunction : arr_next

   logic [`EBR_DATA_W-1:0] mem [`EBR_DEPTH];
   logic [6:0]             ctrl_r, ctrl_nxt;
   logic                   busy_r, busy_nxt;
   logic [`EBR_ADDR_W-1:0] icnt_r, icnt_nxt;
   logic                   wait_r, wait_nxt;
   logic [31:0]            rdat_r, rdat_nxt;
   logic [`EBR_DATA_W-1:0] arr_a_r, arr_a_nxt, arr_b_r, arr_b_nxt;
   logic [`EBR_DATA_W-1:0] dout_a_r, dout_a_nxt, dout_b_r, dout_b_nxt;
   logic                   pipe;
   ebr_wmode_t             wm_a, wm_b;
   ebr_pmode_t             pm;
   logic                   acc_a, acc_b, wr_a, wr_b, bus_req, bus_go;
   logic [`EBR_LANES-1:0]  be_a, be_b;
   logic [`EBR_DATA_W-1:0] q_a, q_b, word_a, word_b;

   // Configuration decode
   assign pipe = ctrl_r[`EBR_CTRL_PIPE];
   assign wm_a = ebr_wmode_t'(ctrl_r[`EBR_CTRL_WMA_LO +: 2]);
   assign wm_b = ebr_wmode_t'(ctrl_r[`EBR_CTRL_WMB_LO +: 2]);
   assign pm   = ebr_pmode_t'(ctrl_r[`EBR_CTRL_PM_LO +: 2]);

   // Port qualification by mode; both ports share the one clock edge
   assign wr_a = port_a_clock_enable_in && port_a_write_enable_in && !busy_r;
   assign acc_a = port_a_clock_enable_in && !busy_r && (pm != EBR_PM_SEMI);
   assign wr_b = port_b_clock_enable_in && port_b_write_enable_in && !busy_r
                 && (pm == EBR_PM_DUAL);
   assign acc_b = port_b_clock_enable_in && !busy_r
                  && (pm == EBR_PM_DUAL || pm == EBR_PM_SEMI);
   assign be_a = (pm == EBR_PM_DUAL) ? (port_a_byte_en_in & `EBR_DUAL_LANES)
                                     : port_a_byte_en_in;
   assign be_b = port_b_byte_en_in & `EBR_DUAL_LANES;
   assign q_a = mem[port_a_addr_in];
   assign q_b = mem[port_b_addr_in];
   assign word_a = merge_word(q_a, port_a_wdata_in, be_a);
   assign word_b = merge_word(q_b, port_b_wdata_in, be_b);

   // Array writes and zero fill during initialisation
   always_ff @(posedge clk_in) begin
      if (busy_r) begin
         mem[icnt_r] <= '0;
      end else begin
         if (wr_a) begin
            mem[port_a_addr_in] <= word_a;
         end
         if (wr_b) begin
            mem[port_b_addr_in] <= word_b;
         end
      end
   end

   // Initialisation sweep
   always_comb begin
      busy_nxt = busy_r;
      icnt_nxt = icnt_r;
      if (busy_r) begin
         icnt_nxt = icnt_r + 1'b1;
         if (icnt_r == `EBR_ADDR_W'(`EBR_DEPTH - 1)) begin
            busy_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy_r <= 1'b1;
         icnt_r <= '0;
      end else begin
         busy_r <= busy_nxt;
         icnt_r <= icnt_nxt;
      end
   end

   // Read paths, output register stage and port resets
   always_comb begin
      arr_a_nxt  = arr_next(arr_a_r, acc_a, wr_a, wm_a, q_a, word_a);
      arr_b_nxt  = arr_next(arr_b_r, acc_b, wr_b, wm_b, q_b, word_b);
      dout_a_nxt = dout_a_r;
      dout_b_nxt = dout_b_r;
      if (pipe) begin
         if (port_a_output_reg_clock_enable_in) begin
            dout_a_nxt = arr_a_r;
         end
         if (port_b_output_reg_clock_enable_in) begin
            dout_b_nxt = arr_b_r;
         end
      end else begin
         dout_a_nxt = arr_a_nxt;
         dout_b_nxt = arr_b_nxt;
      end
      if (port_a_reset_in || busy_r) begin
         arr_a_nxt  = '0;
         dout_a_nxt = '0;
      end
      if (port_b_reset_in || busy_r) begin
         arr_b_nxt  = '0;
         dout_b_nxt = '0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         arr_a_r  <= '0;
         arr_b_r  <= '0;
         dout_a_r <= '0;
         dout_b_r <= '0;
      end else begin
         arr_a_r  <= arr_a_nxt;
         arr_b_r  <= arr_b_nxt;
         dout_a_r <= dout_a_nxt;
         dout_b_r <= dout_b_nxt;
      end
   end

   // Register slave: one wait cycle, then answer
   assign bus_req = avs_read_in || avs_write_in;
   assign bus_go  = bus_req && wait_r;

   always_comb begin
      wait_nxt = 1'b1;
      rdat_nxt = rdat_r;
      ctrl_nxt = ctrl_r;
      if (bus_go) begin
         wait_nxt = 1'b0;
         rdat_nxt = '0;
         if (avs_address_in == `EBR_CTRL_OFS) begin
            rdat_nxt[6:0] = ctrl_r;
         end else if (avs_address_in == `EBR_STAT_OFS) begin
            rdat_nxt[`EBR_STAT_BUSY] = busy_r;
         end
      end
      if (avs_write_in && !wait_r && avs_byteenable_in[0]
          && avs_address_in == `EBR_CTRL_OFS) begin
         ctrl_nxt = avs_writedata_in[6:0];
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wait_r <= 1'b1;
         rdat_r <= '0;
         ctrl_r <= `EBR_CTRL_RST;
      end else begin
         wait_r <= wait_nxt;
         rdat_r <= rdat_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   // Outputs straight from flops
   assign avs_readdata_out     = rdat_r;
   assign avs_waitrequest_out  = wait_r;
   assign port_a_read_data_out = dout_a_r;
   assign port_b_read_data_out = dout_b_r;
   assign init_busy_out        = busy_r;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   // Checks
   a_init_zero: assert property (busy_r |-> dout_a_r == '0 && dout_b_r == '0)
      else $error("outputs not zero during init");
   a_lane_keep: assert property (
      wr_a && !be_a[0] && !(wr_b && port_b_addr_in == port_a_addr_in)
      |=> mem[$past(port_a_addr_in)][8:0] == $past(q_a[8:0]))
      else $error("disabled lane was overwritten");
   a_dual_width: assert property (
      pm == EBR_PM_DUAL && wr_a && !(wr_b && port_b_addr_in == port_a_addr_in)
      |=> mem[$past(port_a_addr_in)][35:18] == $past(q_a[35:18]))
      else $error("upper half written in dual mode");
   a_normal_hold: assert property (
      !pipe && wm_a == EBR_WM_NORMAL && wr_a && !port_a_reset_in
      |=> $stable(dout_a_r))
      else $error("normal write changed output");
   a_thru_word: assert property (
      !pipe && wm_a == EBR_WM_THRU && acc_a && wr_a && !port_a_reset_in
      |=> dout_a_r == $past(word_a))
      else $error("write-through word missing");
   a_rbw_old: assert property (
      !pipe && wm_a == EBR_WM_RBW && acc_a && wr_a && !port_a_reset_in
      |=> dout_a_r == $past(q_a))
      else $error("old word not shown");
   a_pipe_two: assert property (
      (pipe && acc_b && !wr_b && !port_b_reset_in)
      ##1 (pipe && port_b_output_reg_clock_enable_in && !port_b_reset_in && !busy_r)
      |=> dout_b_r == $past(q_b, 2))
      else $error("pipelined read wrong");
   a_oce_hold: assert property (
      pipe && !port_b_output_reg_clock_enable_in && !port_b_reset_in && !busy_r
      |=> $stable(dout_b_r))
      else $error("output reg moved without enable");
   a_single_b_idle: assert property (
      pm == EBR_PM_SINGLE && !port_b_reset_in && !busy_r && !pipe |=> $stable(dout_b_r))
      else $error("port B active in single mode");
   a_semi_a_read: assert property (
      pm == EBR_PM_SEMI && !port_a_reset_in && !busy_r && !pipe |=> $stable(dout_a_r))
      else $error("port A read in semi-dual mode");
   a_bus_answer: assert property (bus_go |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer not one cycle");

endmodule : ebr_top

// *** bench/ebr_fabric_model.sv ***
`timescale 1ns/10ps
module ebr_fabric_model (
   input  wire logic [31:0] payload_in,    // Byte data to store
   output logic      [35:0] word_out,      // Data with lane parity
   input  wire logic [35:0] word_in,       // Word read back
   output logic             parity_ok_out  // Every lane has even parity
);
   // Parity is made and checked in the fabric, never by the memory
   always_comb begin
      parity_ok_out = 1'b1;
      for (int i = 0; i < 4; i++) begin
         word_out[9*i +: 9] = {^payload_in[8*i +: 8], payload_in[8*i +: 8]};
         if (^word_in[9*i +: 9]) parity_ok_out = 1'b0;
      end
   end
endmodule : ebr_fabric_model

// *** bench/ebr_top_tb.sv ***
`timescale 1ns/10ps
module ebr_top_tb;
   import ebr_pkg::*;
   typedef struct {logic [6:0] ctrl; logic we; logic [8:0] ad; logic [35:0] wd;
      logic [3:0] be; logic ck; logic [35:0] ex;} ebr_row_t;
   logic        clk_in = 0, arst_n_in = 0, rd = 0, wr = 0, wt, busy, pok;
   logic [3:0]  ba = 0, be_a = 0;
   logic [31:0] bwd = 0, brd, rdv, pay = 0;
   logic        ce_a = 0, oce_a = 1, rs_a = 0, we_a = 0, ce_b = 0, oce_b = 1, we_b = 0;
   logic [8:0]  ad_a = 0, ad_b = 0;
   logic [35:0] wd_a = 0, do_a, do_b, pw;
   logic [35:0] wd_b = 36'hf_ffff_ffff;
   int          failures = 0, compares = 0, n;
   // Plain cases: mode, access, expected port A data
   ebr_row_t rows [9] = '{
      '{7'h42, 1, 9'h5, 36'h9_1234_5678, 4'hf, 1, 36'h9_1234_5678},
      '{7'h40, 1, 9'h5, 36'h0_aaaa_5555, 4'hf, 1, 36'h9_1234_5678},
      '{7'h44, 1, 9'h5, 36'hf_0f0f_0f0f, 4'hf, 1, 36'h0_aaaa_5555},
      '{7'h40, 0, 9'h5, 36'h0, 4'hf, 1, 36'hf_0f0f_0f0f},
      '{7'h40, 1, 9'h5, 36'h0, 4'h2, 1, 36'hf_0f0f_0f0f},
      '{7'h40, 0, 9'h5, 36'h0, 4'hf, 1, 36'hf_0f0c_010f},
      '{7'h41, 0, 9'h5, 36'h0, 4'hf, 1, 36'hf_0f0c_010f},
      '{7'h00, 1, 9'h6, 36'hf_ffff_ffff, 4'hf, 0, 36'h0},
      '{7'h00, 0, 9'h6, 36'h0, 4'hf, 1, 36'h0_0003_ffff}};
   always #10 clk_in = ~clk_in;
   ebr_top ebr_top_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(ba),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(bwd),
      .avs_byteenable_in(4'hf), .avs_readdata_out(brd), .avs_waitrequest_out(wt),
      .port_a_clock_enable_in(ce_a), .port_a_output_reg_clock_enable_in(oce_a),
      .port_a_reset_in(rs_a), .port_a_write_enable_in(we_a), .port_a_addr_in(ad_a),
      .port_a_wdata_in(wd_a), .port_a_byte_en_in(be_a), .port_a_read_data_out(do_a),
      .port_b_clock_enable_in(ce_b), .port_b_output_reg_clock_enable_in(oce_b),
      .port_b_reset_in(1'b0), .port_b_write_enable_in(we_b), .port_b_addr_in(ad_b),
      .port_b_wdata_in(wd_b), .port_b_byte_en_in(4'hf),
      .port_b_read_data_out(do_b), .init_busy_out(busy));
   ebr_fabric_model ebr_fabric_model_inst (.payload_in(pay), .word_out(pw),
      .word_in(do_a), .parity_ok_out(pok));
   // Compare one result and count it
   task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Print counts and verdict, then stop
   task final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Avalon request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      rd <= !w;
      wr <= w;
      ba <= a;
      bwd <= d;
      do begin
         @(posedge clk_in);
         k++;
      end while (wt !== 1'b0 && k < 20);
      rdv = brd;
      rd <= 0;
      wr <= 0;
      if (k >= 20) begin
         failures++;
         final_report();
      end
   endtask : bus
   // One access edge on the chosen ports, then two edges for the answer
   task acc(input logic [1:0] ce, input logic wa, input logic [8:0] aa,
            input logic [35:0] da, input logic [3:0] bea, input logic wb, input logic [8:0] ab);
      @(posedge clk_in);
      ce_a <= ce[0]; we_a <= wa; ad_a <= aa; wd_a <= da; be_a <= bea;
      ce_b <= ce[1]; we_b <= wb; ad_b <= ab;
      @(posedge clk_in);
      ce_a <= 0; ce_b <= 0; we_a <= 0; we_b <= 0;
      @(posedge clk_in);
      @(negedge clk_in);
   endtask : acc
   initial begin
      repeat (4) @(posedge clk_in);
      chk("rd_a_in_reset", 36'h0, do_a);
      chk("busy_in_reset", 36'h1, busy);
      arst_n_in <= 1;
      bus(0, 4'h4, 32'h0); chk("stat_busy", 36'h1, rdv[0]);
      for (n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clk_in);
      if (busy !== 1'b0) begin failures++; final_report(); end
      chk("rd_a_after_init", 36'h0, do_a);
      bus(0, 4'h0, 32'h0); chk("ctrl_reset", 36'h0, rdv);
      bus(0, 4'h8, 32'h0); chk("unmapped", 36'h0, rdv);
      foreach (rows[i]) begin
         bus(1, 4'h0, {25'h0, rows[i].ctrl});
         acc(2'b01, rows[i].we, rows[i].ad, rows[i].wd, rows[i].be, 0, 0);
         if (rows[i].ck) chk($sformatf("row%0d", i), rows[i].ex, do_a);
      end
      // Output register frozen while its enable is low
      bus(1, 4'h0, 32'h41); bus(0, 4'h0, 32'h0); chk("ctrl_readback", 36'h41, rdv);
      acc(2'b01, 0, 9'h6, 0, 4'hf, 0, 0); chk("pipe_a6", 36'h0_0003_ffff, do_a);
      @(posedge clk_in); oce_a <= 0;
      acc(2'b01, 0, 9'h5, 0, 4'hf, 0, 0); chk("oce_hold", 36'h0_0003_ffff, do_a);
      @(posedge clk_in); oce_a <= 1;
      @(posedge clk_in); @(negedge clk_in); chk("oce_go", 36'hf_0f0c_010f, do_a);
      // Semi-dual: write on A, read on B, B writes refused
      bus(1, 4'h0, 32'h20);
      acc(2'b11, 1, 9'h9, 36'h1_2345_6789, 4'hf, 1, 9'h5);
      acc(2'b10, 0, 0, 0, 4'hf, 0, 9'h5); chk("semi_b_nowr", 36'hf_0f0c_010f, do_b);
      acc(2'b10, 0, 0, 0, 4'hf, 0, 9'h9); chk("semi_b_rd", 36'h1_2345_6789, do_b);
      // Dual: port B writes lanes 0 and 1 only, pipelined B read waits for its enable
      bus(1, 4'h0, 32'h1);
      @(posedge clk_in);
      wd_b <= 36'h5_a5a5_a5a5;
      acc(2'b10, 0, 0, 0, 4'hf, 1, 9'hb);
      acc(2'b10, 0, 0, 0, 4'hf, 0, 9'hb);
      chk("dual_b_lanes", 36'h0_0001_a5a5, do_b);
      @(posedge clk_in);
      oce_b <= 0;
      acc(2'b10, 0, 0, 0, 4'hf, 0, 9'h5);
      chk("oce_b_hold", 36'h0_0001_a5a5, do_b);
      @(posedge clk_in);
      oce_b <= 1;
      @(posedge clk_in);
      @(negedge clk_in);
      chk("oce_b_go", 36'hf_0f0c_010f, do_b);
      // Dual bypass: write-through on port B
      bus(1, 4'h0, 32'h8);
      acc(2'b10, 0, 0, 0, 4'hf, 1, 9'hc);
      chk("thru_b", 36'h0_0001_a5a5, do_b);
      // Fabric parity survives a store and read back
      bus(1, 4'h0, 32'h40);
      @(posedge clk_in);
      pay <= 32'hc3a7_0e81;
      @(posedge clk_in);
      acc(2'b01, 1, 9'ha, pw, 4'hf, 0, 0);
      acc(2'b01, 0, 9'ha, 0, 4'hf, 0, 0); chk("parity_ok", 36'h1, pok);
      chk("parity_word", pw, do_a);
      // Port register reset clears read data
      @(posedge clk_in); rs_a <= 1;
      @(posedge clk_in); rs_a <= 0;
      @(negedge clk_in); chk("port_reset", 36'h0, do_a);
      final_report();
   end
endmodule : ebr_top_tb
